/* File: verilog/pcr_pkg.sv */
package pcr_pkg;

    typedef enum logic [1:0] {
        SZ_BYTE  = 2'b00,
        SZ_WORD  = 2'b01,
        SZ_DWORD = 2'b10
    } pcr_size_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HUB  = 2'b01,
        ST_PEB  = 2'b10
    } pcr_state_e;

    // Host I/O locations of the address register and the data window.
    localparam logic [15:0] IO_CFG_ADDR    = 16'h0cf8;
    localparam logic [15:0] IO_CFG_DATA    = 16'h0cfc;

    // Field positions inside the config address register.
    localparam int          ENABLE_BIT     = 31;
    localparam int          BUS_HI         = 23;
    localparam int          BUS_LO         = 16;
    localparam int          DEV_HI         = 15;
    localparam int          DEV_LO         = 11;
    localparam int          FN_HI          = 10;
    localparam int          FN_LO          = 8;
    localparam int          REG_HI         = 7;
    localparam int          REG_LO         = 2;
    localparam logic [31:0] CFG_ADDR_RST   = 32'h00000000;
    localparam logic [31:0] CFG_ADDR_WMASK = 32'h80fffffc;

    localparam logic [7:0]  BUS_ZERO       = 8'h00;
    localparam logic [4:0]  DEV_HOST       = 5'h00;
    localparam logic [4:0]  DEV_GFX_BRIDGE = 5'h01;
    localparam logic [4:0]  DEV_INT_GFX    = 5'h02;
    localparam int          NUM_INT_DEV    = 3;
    localparam int          NUM_DW         = 4;

    // Per-dword attribute masks of each internal function; {dw3..dw0}.
    // Bits in no mask are read-only.
    localparam logic [3:0][31:0] CFG_RW_MASK  =
        {32'h00000000, 32'h00000000, 32'h0000ffff, 32'h00000000};
    localparam logic [3:0][31:0] CFG_RWC_MASK =
        {32'h00000000, 32'hffff0000, 32'h00000000, 32'h00000000};
    localparam logic [3:0][31:0] CFG_RWO_MASK =
        {32'h000000ff, 32'h00000000, 32'h00000000, 32'h00000000};
    // The identity word value is arbitrary.
    localparam logic [3:0][31:0] CFG_DEFAULT  =
        {32'h00000000, 32'h00000000, 32'h00000000, 32'h5a5a0001};
    localparam int          STRAP_DW       = 3;
    localparam logic [31:0] STRAP_MASK     = 32'h000000ff;
    localparam logic [31:0] RESERVED_READ  = 32'h00000000;
    localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

    // Host controller register map, byte addresses.
    localparam logic [4:0]  AV_CMD         = 5'h00;
    localparam logic [4:0]  AV_ADDR        = 5'h04;
    localparam logic [4:0]  AV_WDATA       = 5'h08;
    localparam logic [4:0]  AV_RDATA       = 5'h0c;
    localparam logic [4:0]  AV_STAT        = 5'h10;
    localparam int          CMD_WR         = 0;
    localparam int          CMD_SIZE_LO    = 1;
    localparam int          STAT_BUSY      = 0;
    localparam int          STAT_DONE      = 1;

endpackage : pcr_pkg

/* File: verilog/pcr_io_if.sv */
interface pcr_io_if;
    logic        io_req;
    logic        io_wr;
    logic [1:0]  io_size;
    logic [15:0] io_addr;
    logic [31:0] io_wdata;
    logic        io_ack;
    logic [31:0] io_rdata;

    modport dev (
        input  io_req,
        input  io_wr,
        input  io_size,
        input  io_addr,
        input  io_wdata,
        output io_ack,
        output io_rdata
    );

    modport host (
        output io_req,
        output io_wr,
        output io_size,
        output io_addr,
        output io_wdata,
        input  io_ack,
        input  io_rdata
    );
endinterface : pcr_io_if

/* File: verilog/pcr_host.sv */
module pcr_host (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    pcr_io_if.host           io,
    input  wire logic [4:0]  av_address,
    input  wire logic        av_read,
    input  wire logic        av_write,
    input  wire logic [31:0] av_writedata,
    output logic      [31:0] av_readdata,
    output logic             av_waitrequest
);
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [2:0]  cmd_reg;
    logic        busy_reg;
    logic        done_reg;
    logic        wait_reg;
    logic [31:0] rd_reg;

    wire         av_start = (av_read | av_write) & wait_reg;
    wire         av_take  = av_write & ~wait_reg;
    wire         wr_cmd   = av_take & (av_address == pcr_pkg::AV_CMD);
    wire         wr_stat  = av_take & (av_address == pcr_pkg::AV_STAT);
    wire         go       = wr_cmd & ~busy_reg;
    wire [31:0]  stat_val = {30'h0, done_reg, busy_reg};
    wire [31:0]  rd_mux   =
        (av_address == pcr_pkg::AV_CMD)   ? {29'h0, cmd_reg} :
        (av_address == pcr_pkg::AV_ADDR)  ? addr_reg :
        (av_address == pcr_pkg::AV_WDATA) ? wdata_reg :
        (av_address == pcr_pkg::AV_RDATA) ? rdata_reg :
        (av_address == pcr_pkg::AV_STAT)  ? stat_val : 32'h00000000;
    wire         clr_done = wr_stat & av_writedata[pcr_pkg::STAT_DONE];

    assign av_readdata    = rd_reg;
    assign av_waitrequest = wait_reg;
    assign io.io_req      = busy_reg;
    assign io.io_wr       = cmd_reg[pcr_pkg::CMD_WR];
    assign io.io_size     = cmd_reg[pcr_pkg::CMD_SIZE_LO +: 2];
    assign io.io_addr     = addr_reg[15:0];
    assign io.io_wdata    = wdata_reg;

    // Every bus access answers on the second edge: one cycle of wait.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_reg <= 1'b1;
            rd_reg   <= 32'h00000000;
        end else if (av_start) begin
            wait_reg <= 1'b0;
            rd_reg   <= rd_mux;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    // Address, data and command stay frozen while a cycle is out, since
    // the device samples them in the cycle that it takes the request.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr_reg  <= 32'h00000000;
            wdata_reg <= 32'h00000000;
            cmd_reg   <= 3'h0;
        end else if (av_take & ~busy_reg) begin
            if (av_address == pcr_pkg::AV_ADDR) begin
                addr_reg <= av_writedata;
            end else if (av_address == pcr_pkg::AV_WDATA) begin
                wdata_reg <= av_writedata;
            end else if (av_address == pcr_pkg::AV_CMD) begin
                cmd_reg <= av_writedata[2:0];
            end
        end
    end

    // A cycle to the address register must use the dword size.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            if (go) begin
                busy_reg <= 1'b1;
            end else if (busy_reg & io.io_ack) begin
                busy_reg  <= 1'b0;
                rdata_reg <= io.io_rdata;
            end
            // A completion in the clearing cycle keeps the flag set.
            if (busy_reg & io.io_ack) begin
                done_reg <= 1'b1;
            end else if (clr_done) begin
                done_reg <= 1'b0;
            end
        end
    end

endmodule : pcr_host

/* File: verilog/pcr_router.sv */
// Decided for this implementation: register access over Avalon-MM and the address map.
module pcr_router (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    pcr_io_if.dev            io,
    input  wire logic [7:0]  strap_pins,
    input  wire logic [47:0] dev_status_set,
    output logic      [47:0] dev_ctrl,
    output logic             hub_req,
    output logic             hub_wr,
    output logic             hub_type1,
    output logic      [23:0] hub_addr,
    output logic      [3:0]  hub_be,
    output logic      [31:0] hub_wdata,
    input  wire logic        hub_ack,
    input  wire logic [31:0] hub_rdata,
    output logic             peb_req,
    output logic             peb_wr,
    output logic      [15:0] peb_addr,
    output logic      [3:0]  peb_be,
    output logic      [31:0] peb_wdata,
    input  wire logic        peb_ack,
    input  wire logic [31:0] peb_rdata
);
    pcr_pkg::pcr_state_e state_reg;
    logic [31:0] config_address_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic        hub_req_reg;
    logic        peb_req_reg;
    logic        fwd_wr_reg;
    logic        hub_type1_reg;
    logic [23:0] hub_addr_reg;
    logic [15:0] peb_addr_reg;
    logic [3:0]  be_reg;
    logic [31:0] wdata_reg;
    logic [31:0] cfg_reg [pcr_pkg::NUM_INT_DEV][pcr_pkg::NUM_DW];
    logic [pcr_pkg::NUM_INT_DEV-1:0] wo_done_reg;
    logic [2:0]  strap_sync_reg;
    logic [7:0]  strap_val_reg;
    logic [1:0]  settle_reg;
    logic        strap_load_reg;

    function automatic logic [3:0] lane_enables(input logic [1:0] a,
                                                input logic [1:0] sz);
        logic [3:0] be;
        be = 4'hf;
        if (sz == pcr_pkg::SZ_BYTE) begin
            be = 4'h1 << a;
        end else if (sz == pcr_pkg::SZ_WORD) begin
            be = 4'h3 << {a[1], 1'b0};
        end
        return be;
    endfunction : lane_enables

    function automatic logic [31:0] merge_bits(input logic [31:0] cur,
                                               input logic [31:0] wd,
                                               input logic [31:0] bm,
                                               input int          w,
                                               input logic        wo_open);
        logic [31:0] rw;
        logic [31:0] rwc;
        logic [31:0] rwo;
        rw  = pcr_pkg::CFG_RW_MASK[w] & bm;
        rwc = pcr_pkg::CFG_RWC_MASK[w] & bm;
        rwo = pcr_pkg::CFG_RWO_MASK[w] & bm & {32{wo_open}};
        return (cur & ~(rw | rwc | rwo)) | (wd & rw)
             | (cur & rwc & ~wd)
             | (wd & rwo);
    endfunction : merge_bits

    wire         idle       = (state_reg == pcr_pkg::ST_IDLE);
    wire         take       = io.io_req & ~ack_reg & idle;
    wire         config_space_enable = config_address_reg[pcr_pkg::ENABLE_BIT];
    wire [7:0]   bus_num    = config_address_reg[pcr_pkg::BUS_HI:pcr_pkg::BUS_LO];
    wire [4:0]   dev_num    = config_address_reg[pcr_pkg::DEV_HI:pcr_pkg::DEV_LO];
    wire [2:0]   fn_num     = config_address_reg[pcr_pkg::FN_HI:pcr_pkg::FN_LO];
    wire [5:0]   reg_num    = config_address_reg[pcr_pkg::REG_HI:pcr_pkg::REG_LO];
    // Only a dword access reaches the address register.
    wire         addr_hit   = (io.io_addr == pcr_pkg::IO_CFG_ADDR)
                            & (io.io_size == pcr_pkg::SZ_DWORD);
    wire         config_data_window = config_space_enable
                            & (io.io_addr[15:2] == pcr_pkg::IO_CFG_DATA[15:2]);
    wire         bus0       = (bus_num == pcr_pkg::BUS_ZERO);
    wire         dev_host   = bus0 & (dev_num == pcr_pkg::DEV_HOST);
    wire         dev_bridge = bus0 & (dev_num == pcr_pkg::DEV_GFX_BRIDGE);
    wire         dev_igd    = bus0 & (dev_num == pcr_pkg::DEV_INT_GFX);
    wire         internal   = dev_host | dev_bridge | dev_igd;
    wire [1:0]   dev_idx    = dev_num[1:0];
    // Function 0, first four dwords are implemented; the rest of the
    // 8 x 256 byte space of an internal device is reserved.
    wire         reg_impl   = (fn_num == 3'h0) & (reg_num[5:2] == 4'h0);
    wire [3:0]   lanes      = lane_enables(io.io_addr[1:0], io.io_size);
    wire [31:0]  lane_mask  = {{8{lanes[3]}}, {8{lanes[2]}},
                               {8{lanes[1]}}, {8{lanes[0]}}};
    wire         int_cycle  = take & config_data_window & internal;
    wire         int_write  = int_cycle & io.io_wr & reg_impl;
    wire         hub_cycle  = take & config_data_window & ~internal;
    wire         peb_cycle  = take & ~addr_hit & ~config_data_window;
    // Reserved locations read as zero and ignore writes.
    wire [31:0]  int_rdata  = reg_impl ? cfg_reg[dev_idx][reg_num[1:0]]
                                       : pcr_pkg::RESERVED_READ;

    assign io.io_ack   = ack_reg;
    assign io.io_rdata = rdata_reg;
    assign hub_req     = hub_req_reg;
    assign hub_wr      = fwd_wr_reg;
    assign hub_type1   = hub_type1_reg;
    assign hub_addr    = hub_addr_reg;
    assign hub_be      = be_reg;
    assign hub_wdata   = wdata_reg;
    assign peb_req     = peb_req_reg;
    assign peb_wr      = fwd_wr_reg;
    assign peb_addr    = peb_addr_reg;
    assign peb_be      = be_reg;
    assign peb_wdata   = wdata_reg;

    // Straps come from pins; a new level counts once stages two and three
    // agree, and the value is loaded a few cycles after reset release.
    always_ff @(posedge sys_clk) begin
        strap_sync_reg <= {strap_sync_reg[1:0], strap_pins[0]};
        if (srst) begin
            settle_reg     <= 2'h0;
            strap_load_reg <= 1'b0;
        end else begin
            strap_load_reg <= (settle_reg == pcr_pkg::STRAP_SETTLE - 2'h1);
            if (settle_reg != pcr_pkg::STRAP_SETTLE) begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    genvar gb;
    generate
        for (gb = 1; gb < 8; gb++) begin : g_strap_sync
            logic [2:0] sync_reg;
            always_ff @(posedge sys_clk) begin
                sync_reg <= {sync_reg[1:0], strap_pins[gb]};
                if (sync_reg[1] == sync_reg[2]) begin
                    strap_val_reg[gb] <= sync_reg[2];
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (strap_sync_reg[1] == strap_sync_reg[2]) begin
            strap_val_reg[0] <= strap_sync_reg[2];
        end
    end

    genvar gd, gw;
    generate
        for (gd = 0; gd < pcr_pkg::NUM_INT_DEV; gd++) begin : g_dev
            wire wr_dev = int_write & (dev_idx == 2'(gd));
            for (gw = 0; gw < pcr_pkg::NUM_DW; gw++) begin : g_dw
                wire        hit  = wr_dev & (reg_num[1:0] == 2'(gw));
                wire [31:0] cur  = cfg_reg[gd][gw];
                wire [31:0] mrg  = hit ? merge_bits(cur, io.io_wdata, lane_mask,
                                                    gw, ~wo_done_reg[gd])
                                       : cur;
                wire [31:0] hset = {dev_status_set[16*gd +: 16], 16'h0000}
                                 & pcr_pkg::CFG_RWC_MASK[gw];
                // The strap field loads once after reset release.
                wire        ldst = strap_load_reg & (gw == pcr_pkg::STRAP_DW);
                wire [31:0] nxt  = ldst ? ((mrg & ~pcr_pkg::STRAP_MASK)
                                           | {24'h0, strap_val_reg})
                                        : mrg;
                always_ff @(posedge sys_clk) begin
                    if (srst) begin
                        cfg_reg[gd][gw] <= pcr_pkg::CFG_DEFAULT[gw];
                    end else begin
                        // Hardware set beats a clearing write.
                        cfg_reg[gd][gw] <= nxt | hset;
                    end
                end
            end
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    wo_done_reg[gd] <= 1'b0;
                end else if (wr_dev & (reg_num[1:0] == pcr_pkg::STRAP_DW)) begin
                    wo_done_reg[gd] <= 1'b1;
                end
            end
            assign dev_ctrl[16*gd +: 16] = cfg_reg[gd][1][15:0];
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            config_address_reg <= pcr_pkg::CFG_ADDR_RST;
        end else if (take & addr_hit & io.io_wr) begin
            // Reserved bits of the address register stay zero.
            config_address_reg <= io.io_wdata & pcr_pkg::CFG_ADDR_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (hub_cycle | peb_cycle) begin
            fwd_wr_reg    <= io.io_wr;
            hub_type1_reg <= ~bus0;
            hub_addr_reg  <= config_address_reg[23:0];
            peb_addr_reg  <= io.io_addr;
            be_reg        <= peb_cycle ? lane_enables(io.io_addr[1:0],
                                                      io.io_size)
                                       : lanes;
            wdata_reg     <= io.io_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg   <= pcr_pkg::ST_IDLE;
            ack_reg     <= 1'b0;
            rdata_reg   <= 32'h00000000;
            hub_req_reg <= 1'b0;
            peb_req_reg <= 1'b0;
        end else begin
            ack_reg <= 1'b0;
            case (state_reg)
                pcr_pkg::ST_IDLE: begin
                    if (take & addr_hit) begin
                        ack_reg   <= 1'b1;
                        rdata_reg <= config_address_reg;
                    end else if (int_cycle) begin
                        ack_reg   <= 1'b1;
                        rdata_reg <= int_rdata;
                    end else if (hub_cycle) begin
                        hub_req_reg <= 1'b1;
                        state_reg   <= pcr_pkg::ST_HUB;
                    end else if (peb_cycle) begin
                        peb_req_reg <= 1'b1;
                        state_reg   <= pcr_pkg::ST_PEB;
                    end
                end
                pcr_pkg::ST_HUB: begin
                    if (hub_ack) begin
                        hub_req_reg <= 1'b0;
                        ack_reg     <= 1'b1;
                        rdata_reg   <= hub_rdata;
                        state_reg   <= pcr_pkg::ST_IDLE;
                    end
                end
                pcr_pkg::ST_PEB: begin
                    if (peb_ack) begin
                        peb_req_reg <= 1'b0;
                        ack_reg     <= 1'b1;
                        rdata_reg   <= peb_rdata;
                        state_reg   <= pcr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= pcr_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule : pcr_router

/* File: tb/pcr_chk.sv */
module pcr_chk (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        io_req,
    input wire logic        io_wr,
    input wire logic [1:0]  io_size,
    input wire logic [15:0] io_addr,
    input wire logic [31:0] io_wdata,
    input wire logic        io_ack,
    input wire logic        hub_req,
    input wire logic        hub_type1,
    input wire logic [23:0] hub_addr,
    input wire logic        peb_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic        req_d_reg;
    logic [31:0] sel_reg;
    wire logic   tk  = io_req && !req_d_reg;
    wire logic   adr = io_addr == pcr_pkg::IO_CFG_ADDR;
    wire logic   dw  = io_size == pcr_pkg::SZ_DWORD;
    wire logic   win = io_addr[15:2] == pcr_pkg::IO_CFG_DATA[15:2];
    wire logic   en  = sel_reg[31];
    wire logic   b0  = sel_reg[23:16] == 8'h00;
    wire logic   idv = sel_reg[15:11] < 5'h03;
    // A shadow of the address register lets routing be judged at each take.
    always_ff @(posedge sys_clk) begin
        req_d_reg <= srst ? 1'b0 : io_req;
        if (srst)
            sel_reg <= pcr_pkg::CFG_ADDR_RST;
        else if (io_ack && io_wr && adr && dw)
            sel_reg <= io_wdata & pcr_pkg::CFG_ADDR_WMASK;
    end
    property p_addr_dw; tk && adr && dw |=> io_ack && !hub_req; endproperty
    a_addr_dw: assert property (p_addr_dw)
        else $error("address register access not answered");
    property p_pass; tk && adr && !dw |=> peb_req && !io_ack; endproperty
    a_pass: assert property (p_pass)
        else $error("narrow address access not passed through");
    property p_off; tk && win && !en |=> peb_req && !hub_req; endproperty
    a_off: assert property (p_off)
        else $error("disabled window access not passed through");
    property p_int; tk && win && en && b0 && idv |=> io_ack && !hub_req;
    endproperty
    a_int: assert property (p_int)
        else $error("internal device cycle left the block");
    property p_fwd0; tk && win && en && b0 && !idv |=> hub_req && !hub_type1;
    endproperty
    a_fwd0: assert property (p_fwd0)
        else $error("bus zero device not forwarded as type 0");
    property p_fwd1; tk && win && en && !b0 |=> hub_req && hub_type1; endproperty
    a_fwd1: assert property (p_fwd1)
        else $error("non-zero bus not forwarded as type 1");
    property p_haddr; $rose(hub_req) |-> hub_addr == sel_reg[23:0]; endproperty
    a_haddr: assert property (p_haddr)
        else $error("hub address does not match selection");
    property p_answer; tk |-> ##[1:40] io_ack; endproperty
    a_answer: assert property (p_answer)
        else $error("access never answered");
    property p_rst; disable iff (1'b0) srst |=> !io_ack && !hub_req && !peb_req;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs active after reset");
endmodule : pcr_chk

/* File: tb/test_pci_config_access_router.sv */
module test_pci_config_access_router;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, srst, av_read, av_write, av_waitrequest;
    logic        hub_req, hub_wr, hub_type1, hub_ack, peb_req, peb_wr, peb_ack;
    logic [4:0]  av_address;
    logic [7:0]  strap_pins;
    logic [15:0] peb_addr;
    logic [23:0] hub_addr;
    logic [3:0]  hub_be, peb_be;
    logic [31:0] av_writedata, av_readdata, hub_wdata, hub_rdata;
    logic [31:0] peb_wdata, peb_rdata, rd;
    logic [47:0] dev_status_set, dev_ctrl;
    logic [31:0] hv [3] = '{32'h80001810, 32'h8000f810, 32'h80050100};
    int          n_fail;
    int          n_tests;
    pcr_io_if u_pcr_io_if ();
    pcr_host u_pcr_host (.sys_clk, .srst, .io(u_pcr_io_if), .av_address,
        .av_read, .av_write, .av_writedata, .av_readdata, .av_waitrequest);
    pcr_router u_pcr_router (.sys_clk, .srst, .io(u_pcr_io_if), .strap_pins,
        .dev_status_set, .dev_ctrl, .hub_req, .hub_wr, .hub_type1, .hub_addr,
        .hub_be, .hub_wdata, .hub_ack, .hub_rdata, .peb_req, .peb_wr,
        .peb_addr, .peb_be, .peb_wdata, .peb_ack, .peb_rdata);
    pcr_chk u_pcr_chk (.sys_clk, .srst, .io_req(u_pcr_io_if.io_req),
        .io_wr(u_pcr_io_if.io_wr), .io_size(u_pcr_io_if.io_size),
        .io_addr(u_pcr_io_if.io_addr), .io_wdata(u_pcr_io_if.io_wdata),
        .io_ack(u_pcr_io_if.io_ack), .hub_req, .hub_type1, .hub_addr,
        .peb_req);
    // Released return data is inverted so a stale sample cannot match.
    // A write echoes its data; a read reports its lanes and address.
    assign hub_rdata = (hub_wr ? hub_wdata : {4'ha, hub_be, hub_addr})
                     ^ {32{!hub_ack}};
    assign peb_rdata = (peb_wr ? peb_wdata : {4'hc, peb_be, 8'h00, peb_addr})
                     ^ {32{!peb_ack}};
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) begin
        hub_ack <= hub_req && !hub_ack;
        peb_ack <= peb_req && !peb_ack;
    end
    task wrap_up;
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task av(input logic w, input logic [4:0] a, input logic [31:0] d);
        av_address   <= a;
        av_writedata <= d;
        av_write     <= w;
        av_read      <= !w;
        @(posedge sys_clk);
        while (av_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = av_readdata;
        av_write <= 1'b0;
        av_read  <= 1'b0;
        @(posedge sys_clk);
    endtask : av
    task io(input logic w, input logic [1:0] s, input logic [15:0] a,
            input logic [31:0] d);
        av(1'b1, pcr_pkg::AV_ADDR, {16'h0000, a});
        av(1'b1, pcr_pkg::AV_WDATA, d);
        av(1'b1, pcr_pkg::AV_CMD, {29'h0, s, w});
        rd = 32'h0;
        while (rd[pcr_pkg::STAT_DONE] !== 1'b1)
            av(1'b0, pcr_pkg::AV_STAT, 32'h0);
        av(1'b1, pcr_pkg::AV_STAT, 32'h00000002);
        av(1'b0, pcr_pkg::AV_RDATA, 32'h0);
    endtask : io
    task win(input logic [31:0] sel, input logic w, input logic [1:0] s,
             input logic [1:0] o, input logic [31:0] d);
        io(1'b1, pcr_pkg::SZ_DWORD, pcr_pkg::IO_CFG_ADDR, sel);
        io(w, s, pcr_pkg::IO_CFG_DATA | {14'h0, o}, d);
    endtask : win
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail++;
        wrap_up;
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        srst = 1'b1;
        {av_read, av_write, av_address, av_writedata} = '0;
        dev_status_set = '0;
        strap_pins = 8'h3c;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        av(1'b0, 5'h14, 32'h0);
        chk(rd, 32'h0);
        io(1'b1, pcr_pkg::SZ_DWORD, pcr_pkg::IO_CFG_ADDR, 32'hffffffff);
        io(1'b0, pcr_pkg::SZ_DWORD, pcr_pkg::IO_CFG_ADDR, 32'h0);
        chk(rd, pcr_pkg::CFG_ADDR_WMASK);
        io(1'b0, pcr_pkg::SZ_BYTE, pcr_pkg::IO_CFG_ADDR, 32'h0);
        chk(rd, 32'hc1000cf8);
        for (int d = 0; d < 3; d++) begin
            win(32'h80000000 | (d << 11), 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 0);
            chk(rd, pcr_pkg::CFG_DEFAULT[0]);
        end
        for (int i = 0; i < 3; i++) begin
            win(hv[i], 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
            chk(rd, {8'haf, hv[i][23:0]});
        end
        win(hv[0], 1'b1, pcr_pkg::SZ_DWORD, 2'h0, 32'h13579bdf);
        chk(rd, 32'h13579bdf);
        win(hv[2], 1'b0, pcr_pkg::SZ_WORD, 2'h2, 32'h0);
        chk(rd, {8'hac, hv[2][23:0]});
        win(32'h00000804, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'hcf000cfc);
        win(32'h80000804, 1'b1, pcr_pkg::SZ_DWORD, 2'h0, 32'h12345678);
        win(32'h80000804, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h00005678);
        win(32'h80000804, 1'b1, pcr_pkg::SZ_BYTE, 2'h1, 32'h0000ab00);
        win(32'h80000804, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h0000ab78);
        chk({16'h0000, dev_ctrl[31:16]}, 32'h0000ab78);
        rd = {rd[31:16], 16'h1234};
        win(32'h80000804, 1'b1, pcr_pkg::SZ_DWORD, 2'h0, rd);
        win(32'h80000804, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h00001234);
        dev_status_set <= 48'h00f0;
        @(posedge sys_clk);
        dev_status_set <= 48'h0;
        win(32'h80000008, 1'b1, pcr_pkg::SZ_DWORD, 2'h0, 32'h00300000);
        win(32'h80000008, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h00c00000);
        win(32'h8000100c, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h0000003c);
        win(32'h8000100c, 1'b1, pcr_pkg::SZ_DWORD, 2'h0, 32'h000000a5);
        win(32'h8000100c, 1'b1, pcr_pkg::SZ_DWORD, 2'h0, 32'h0000005a);
        win(32'h8000100c, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h000000a5);
        win(32'h800007fc, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, pcr_pkg::RESERVED_READ);
        srst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (5) @(posedge sys_clk);
        io(1'b0, pcr_pkg::SZ_DWORD, pcr_pkg::IO_CFG_ADDR, 32'h0);
        chk(rd, pcr_pkg::CFG_ADDR_RST);
        win(32'h80000804, 1'b0, pcr_pkg::SZ_DWORD, 2'h0, 32'h0);
        chk(rd, 32'h0);
        wrap_up;
    end
endmodule : test_pci_config_access_router
